// ==== odc_fifo.sv ====
// Frame FIFO between the serial shifter and the parallel latch
`timescale 1ns/1ps
module odc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    // Full when pointers differ only in the wrap bit
    assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) &&
                         (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = (wr_ptr != rd_ptr);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    // Storage array, no reset needed
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    no_overflow_a: assert property (!in_ready |=> $stable(wr_ptr))
        else $error("fifo write pointer moved while full");
endmodule

// ==== odc_host_model.sv ====
// Behavioural host SPI master facing the serial control block
`timescale 1ns/1ps
module odc_host_model (
    input  wire logic clock,
    output logic      cs_n,
    output logic      sclk,
    output logic      si,
    input  wire logic so_out,
    input  wire logic so_oe
);
    logic oe_seen;

    // Pins idle: deselected, serial clock parked low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
        oe_seen = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Let k system clocks pass, then act just after the edge
    task automatic hold(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask

    // One frame of nb bits, MSB first; each clock level lasts 4 clocks
    task automatic xfer(input int nb, input logic [15:0] tx,
                        output logic [15:0] rx);
        rx = 16'h0000;
        oe_seen = 1'b1;
        cs_n = 1'b0;
        hold(4);
        for (int i = nb - 1; i >= 0; i--) begin
            si = tx[i];
            sclk = 1'b1;
            hold(4);
            sclk = 1'b0;
            hold(4);
            rx = {rx[14:0], so_oe ? so_out : !so_out};  // Loose line flips
            oe_seen &= so_oe;
        end
        si = ~si;  // No stale level once the data is spent
        hold(4);
        cs_n = 1'b1;
        hold(4);
    endtask

    // Serial clock pulses with select high; the clock ends parked low
    task automatic stray(input int nb);
        for (int i = 0; i < nb; i++) begin
            sclk = 1'b1;
            hold(4);
            sclk = 1'b0;
            hold(4);
        end
    endtask
endmodule

// ==== odc_pkg.sv ====
// Package of constants and types for the octal driver serial control block
package odc_pkg;
    localparam int          CHANNELS         = 8;
    localparam int          CLOCK_HZ         = 25_000_000;
    localparam int          BLANK_US         = 160;
    localparam int          BLANK_CYCLES     = BLANK_US * (CLOCK_HZ / 1_000_000);
    localparam int          CNT_W            = 12;
    localparam int          FIFO_DEPTH       = 16;
    localparam logic [7:0]  SHIFT_RESET      = 8'h00;
    localparam logic [7:0]  LATCH_RESET      = 8'h00;
    localparam logic [11:0] CNT_ZERO         = 12'h000;
    localparam logic [11:0] CNT_LOAD         = 12'(BLANK_CYCLES - 1);

    // Synchronised link pins
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic si;
    } odc_link_t;

    localparam odc_link_t   LINK_IDLE        = '{cs_n: 1'b1, sclk: 1'b0,
                                                 si: 1'b0};
endpackage

// ==== odc_serial_ctrl.sv ====
// Serial control, latch and fault blanking of the octal low-side driver
`timescale 1ns/1ps
module odc_serial_ctrl
    import odc_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire logic                reset_n,
    input  wire logic                cs_n,
    input  wire logic                sclk,
    input  wire logic                si,
    output logic                     so_out,
    output logic                     so_oe,
    input  wire logic [CHANNELS-1:0] out_high,
    output logic      [CHANNELS-1:0] out_on,
    output logic                     blanking,
    input  wire logic                latch_hold,
    output logic                     frame_ready
);
    odc_link_t             link_s1;
    odc_link_t             link_s2;
    odc_link_t             link_s3;
    logic [CHANNELS-1:0]   high_s1;
    logic [CHANNELS-1:0]   high_s;
    logic [CHANNELS-1:0]   shift;
    logic [CHANNELS-1:0]   latch;
    logic [CNT_W-1:0]      count;
    logic                  sel;
    logic                  cs_fall;
    logic                  cs_rise;
    logic                  sck_rise;
    logic                  sck_fall;
    logic [CHANNELS-1:0]   fifo_data;
    logic                  fifo_valid;
    logic                  load;
    logic [1:0]            rst_sync;
    logic                  dev_rst_n;

    ////////////////////////////////////////////////////////////////////////
    // Reset pin: clears at once but lets go only on a clock edge, two
    // stages later, so no flip-flop leaves reset in the middle of a cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync <= '0;
        end else begin
            rst_sync <= {rst_sync[0], 1'h1};
        end
    end

    assign dev_rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; stage one feeds stage two only
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            link_s1 <= LINK_IDLE;
            link_s2 <= LINK_IDLE;
            link_s3 <= LINK_IDLE;
            high_s1 <= '0;
            high_s  <= '0;
        end else begin
            link_s1 <= '{cs_n: cs_n, sclk: sclk, si: si};
            link_s2 <= link_s1;
            link_s3 <= link_s2;
            high_s1 <= out_high;
            high_s  <= high_s1;
        end
    end

    // Edge finders work on the settled stages only
    assign sel      = !link_s2.cs_n;
    assign cs_fall  = link_s3.cs_n && !link_s2.cs_n;
    assign cs_rise  = !link_s3.cs_n && link_s2.cs_n;
    assign sck_rise = sel && !link_s3.sclk && link_s2.sclk;
    assign sck_fall = sel && link_s3.sclk && !link_s2.sclk;

    ////////////////////////////////////////////////////////////////////////
    // Shift register: jam diagnostics on select fall, shift on clock fall.
    // A clock edge coinciding with select fall is dropped, as the host is
    // expected to hold the clock low there.
    always_ff @(posedge clock or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            shift <= SHIFT_RESET;
        end else if (sys_rst) begin
            shift <= SHIFT_RESET;
        end else if (cs_fall) begin
            shift <= high_s;
        end else if (sck_fall) begin
            shift <= {shift[CHANNELS-2:0], link_s2.si};
        end
    end

    // Serial out follows the MSB after each clock rise while selected
    always_ff @(posedge clock or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            so_out <= 1'b0;
        end else if (sys_rst) begin
            so_out <= 1'b0;
        end else if (sck_rise) begin
            so_out <= shift[CHANNELS-1];
        end
    end

    // Drive serial out only while selected
    assign so_oe = sel;

    ////////////////////////////////////////////////////////////////////////
    // Frames queue here, up to 16, so a slow latch consumer loses a frame only when the queue is full
    odc_fifo #(
        .WIDTH (CHANNELS),
        .DEPTH (FIFO_DEPTH)
    ) i_odc_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .in_data   (shift),
        .in_valid  (cs_rise),
        .in_ready  (frame_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (!latch_hold)
    );

    assign load = fifo_valid && !latch_hold;

    ////////////////////////////////////////////////////////////////////////
    // Parallel latch holds ON state; a zero command bit means ON.
    // Fault clearing runs every cycle while the timer is idle, so an
    // output that is shorted again in a later frame drops out again.
    always_ff @(posedge clock or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            latch <= LATCH_RESET;
        end else if (sys_rst) begin
            latch <= LATCH_RESET;
        end else if (load) begin
            latch <= ~fifo_data;
        end else if (!blanking) begin
            latch <= latch & ~high_s;
        end
    end

    assign out_on = latch;

    // Blanking timer restarts with every frame loaded into the latch
    always_ff @(posedge clock or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            count    <= CNT_ZERO;
            blanking <= 1'b0;
        end else if (sys_rst) begin
            count    <= CNT_ZERO;
            blanking <= 1'b0;
        end else if (load) begin
            count    <= CNT_LOAD;
            blanking <= 1'b1;
        end else if (count != CNT_ZERO) begin
            count    <= count - 1'b1;
        end else begin
            blanking <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst || !dev_rst_n);

    // Named steps of the blanking behaviour
    sequence load_s;
        load;
    endsequence

    sequence blank_run_s;
        blanking [*8];
    endsequence

    // Last cycle of a running timer with no new frame arriving
    sequence blank_last_s;
        blanking && (count == CNT_ZERO) && !load;
    endsequence

    // Link side: serial out, shifting and clock gating
    so_first_bit_a: assert property (sck_rise |=>
        so_out == $past(shift[CHANNELS-1]))
        else $error("serial out did not follow shift MSB");
    so_hold_a: assert property (!sck_rise |=>
        $stable(so_out))
        else $error("serial out moved without a clock rise");
    shift_capture_a: assert property (sck_fall && !cs_fall |=>
        shift == {$past(shift[CHANNELS-2:0]), $past(link_s2.si)})
        else $error("serial in not captured on clock fall");
    shift_hold_a: assert property (!sck_fall && !cs_fall |=>
        $stable(shift))
        else $error("shift register moved without a clock fall");
    clock_gate_a: assert property (!sel && !cs_fall |=>
        $stable(shift) && $stable(so_out))
        else $error("shift state moved while deselected");
    diag_jam_a: assert property (cs_fall |=>
        shift == $past(high_s))
        else $error("diagnostics not jammed at select fall");
    so_enable_a: assert property (cs_fall |=> so_oe [*2])
        else $error("serial out not enabled while selected");
    so_release_a: assert property (cs_rise |=> !so_oe)
        else $error("serial out still driven after deselect");

    // Latch and timer side
    latch_load_a: assert property (load |=>
        latch == ~$past(fifo_data))
        else $error("latch did not take the frame");
    frame_queue_a: assert property (cs_rise && frame_ready |=>
        fifo_valid)
        else $error("frame not queued at select rise");
    stall_keep_a: assert property (latch_hold |=>
        (latch & ~$past(latch)) == LATCH_RESET)
        else $error("output turned on while frames were stalled");
    blank_start_a: assert property (load_s |=> blank_run_s)
        else $error("blanking did not start on load");
    blank_end_a: assert property (blank_last_s |=> !blanking)
        else $error("blanking outlived its timer");
    blank_hold_a: assert property (blanking && !load |=>
        $stable(latch))
        else $error("latch changed during blanking");
    fault_clear_a: assert property (!blanking && !load |=>
        (latch & $past(high_s)) == LATCH_RESET)
        else $error("faulted output left ON after blanking");
endmodule

// ==== odc_serial_ctrl_tb.sv ====
// Self-checking bench of the octal driver serial control block
`timescale 1ns/1ps
module odc_serial_ctrl_tb import odc_pkg::*;;
    logic        clock, sys_rst, reset_n, cs_n, sclk, si, so_out, so_oe;
    logic        blanking, latch_hold, frame_ready;
    logic [7:0]  out_high, out_on, mid;
    logic [15:0] rx;
    int          n, n_errors, num_checks;

    odc_serial_ctrl i_odc_serial_ctrl (.clock(clock), .sys_rst(sys_rst),
        .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .si(si),
        .so_out(so_out), .so_oe(so_oe), .out_high(out_high),
        .out_on(out_on), .blanking(blanking), .latch_hold(latch_hold),
        .frame_ready(frame_ready));
    odc_host_model i_odc_host_model (.clock(clock), .cs_n(cs_n),
        .sclk(sclk), .si(si), .so_out(so_out), .so_oe(so_oe));

    ////////////////////////////////////////////////////////////////////////
    // Compare and count; a mismatch is reported at once
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        if (seen !== exp)
            n_errors++;
    endtask

    task automatic hold(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask

    task automatic give_verdict();
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Write, read back diagnostics, then let a fault clear after blanking
    task automatic t_write_fault();
        out_high = 8'h3C;
        i_odc_host_model.xfer(8, 16'h00A5, rx);
        check("diag byte", 16'(rx[7:0]), 16'h003C);
        check("so driven", 16'(i_odc_host_model.oe_seen), 16'h0001);
        check("so released", 16'(so_oe), 16'h0000);
        n = 0;
        while (blanking !== 1'b1 && n < 20) begin
            hold(1);
            n++;
        end
        check("latch load", 16'(out_on), 16'h005A);
        out_high = 8'h2F;  // Shorts on 1 and 3, open load on 7
        n = 0;
        while (blanking === 1'b1 && n < 5000) begin
            if (n == 3990)
                mid = out_on;
            hold(1);
            n++;
        end
        check("blank length", 16'(n), 16'(BLANK_CYCLES));
        check("blank hold", 16'(mid), 16'h005A);
        hold(4);
        check("fault clear", 16'(out_on), 16'h0050);
        i_odc_host_model.xfer(8, 16'h00A5, rx);
        check("short map", 16'(8'h5A & rx[7:0]), 16'h000A);
        check("open map", 16'(8'hA5 & ~rx[7:0]), 16'h0080);
        hold(8);
        reset_n = 1'b0;
        hold(1);
        check("async clear", 16'(out_on), 16'h0000);
        reset_n = 1'b1;
        hold(2);
    endtask

    // Sixteen clocks in one frame: first byte passes through, last wins
    task automatic t_chain();
        out_high = 8'h00;
        i_odc_host_model.xfer(16, 16'hC33C, rx);
        hold(8);
        check("chain diag", 16'(rx[15:8]), 16'h0000);
        check("chain pass", 16'(rx[7:0]), 16'h00C3);
        check("last byte wins", 16'(out_on), 16'h00C3);
    endtask

    // Clock pulses while deselected after the chain frame: serial out
    // keeps the last bit shown (bit 8 of the chain word), latch stays
    task automatic t_gate();
        i_odc_host_model.stray(6);
        hold(4);
        check("gated so", 16'(so_out), 16'h0001);
        check("gated latch", 16'(out_on), 16'h00C3);
    endtask

    // Fill the frame queue with the latch stalled, overflow, then drain
    task automatic t_fifo();
        latch_hold = 1'b1;
        for (int k = 0; k < 17; k++) begin
            if (k == 16)
                check("queue full", 16'(frame_ready), 16'h0000);
            i_odc_host_model.xfer(8, 16'(k), rx);
        end
        check("held latch", 16'(out_on), 16'h00C3);
        latch_hold = 1'b0;
        hold(40);
        check("drained", 16'(out_on), 16'h00F0);
        check("queue room", 16'(frame_ready), 16'h0001);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // 25 MHz system clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        reset_n = 1'b1;
        latch_hold = 1'b0;
        out_high = 8'h00;
        n_errors = 0;
        num_checks = 0;
        hold(12);
        sys_rst = 1'b0;
        hold(3);
        check("reset state", 16'({so_oe, blanking, out_on}), 16'h0000);
        t_write_fault();
        t_chain();
        t_gate();
        t_fifo();
        give_verdict();
    end

    // Watchdog: the tests need about 5700 cycles
    initial begin
        #(30000 * 40);
        n_errors++;
        give_verdict();
    end
endmodule
